// [logic/sms_regs.svh]
// Purpose: Constants of the step/dir microstep sequencer
// Assumes: 50 MHz system clock
// Notes: Command word layouts, timing counts, reset values
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH

`define SMS_WORD_W 20
`define SMS_KIND_HI 19
`define SMS_KIND_LO 18
`define SMS_KIND_COIL 2'h0
`define SMS_KIND_CONF 2'h1
`define SMS_COILA_SIGN 17
`define SMS_COILA_HI 16
`define SMS_COILA_LO 9
`define SMS_COILB_SIGN 8
`define SMS_COILB_HI 7
`define SMS_COILB_LO 0
`define SMS_CONF_RES_HI 3
`define SMS_CONF_RES_LO 0
`define SMS_CONF_DUAL_EDGE_STEP_SELECT 4
`define SMS_CONF_STEPDIS 5
`define SMS_CONF_CHOP 6
`define SMS_RES_MAX 4'h8
`define SMS_RST_RES 4'h0
`define SMS_RST_DUAL_EDGE_STEP_SELECT 1'b0
`define SMS_RST_STEPDIS 1'b0
`define SMS_RST_CHOP 1'b0
`define SMS_CLK_MHZ 50
`define SMS_TOFF_NS 2000
`define SMS_TOFF_CYC ((`SMS_TOFF_NS * `SMS_CLK_MHZ + 999) / 1000)
`define SMS_TFAST_CYC (`SMS_TOFF_CYC / 2)

`endif

// [logic/sms_pkg.sv]
// Purpose: Types of the step/dir microstep sequencer
// Assumes: Used with sms_regs.svh
// Notes: Coil target carries sign and magnitude
package sms_pkg;
    typedef struct packed {
        logic sign;
        logic [7:0] mag;
    } sms_coil_t;

    typedef struct packed {
        logic chop_spread;
        logic step_disable;
        logic dual_edge_step_select;
        logic [3:0] res;
    } sms_conf_t;

    typedef enum logic [1:0] {
        SMS_CH_ON = 2'b00,
        SMS_CH_FAST = 2'b01,
        SMS_CH_SLOW = 2'b10
    } sms_chop_t;
endpackage : sms_pkg

// [logic/sms_sequencer.sv]
// Purpose: Step/dir microstep sequencer with serial command port
// Assumes: Pins are asynchronous to i_clk_sys; 50 MHz system clock
// Notes: Coil currents come from sine table or direct serial writes
`timescale 1ns/1ps
`include "sms_regs.svh"

module sms_sequencer #(
    parameter int TOFF_CYC = `SMS_TOFF_CYC,
    parameter int TFAST_CYC = `SMS_TFAST_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Serial port
    input wire logic i_chip_select_low,
    input wire logic i_sck,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // Step and direction
    input wire logic i_step,
    input wire logic i_dir,
    // Clock pin and driver enable
    input wire logic i_ext_clk,
    input wire logic i_driver_enable_low,
    output logic o_use_ext_clk,
    // Current sense comparators, one per coil, high above target
    input wire logic [1:0] i_coil_over,
    // Coil targets and bridge switch drives {h1,h2,l1,l2} per coil
    output sms_pkg::sms_coil_t o_coil_a,
    output sms_pkg::sms_coil_t o_coil_b,
    output logic [7:0] o_bridge,
    // Microstep position
    output logic [9:0] o_position
);
    if (TOFF_CYC < 2 || TFAST_CYC < 1 || TFAST_CYC >= TOFF_CYC) begin : g_bad
        $error("sms_sequencer: bad chopper timing");
    end

    localparam int NSYNC = 7;
    // Idle pin levels: select and enable start inactive, no false edge
    localparam logic [NSYNC-1:0] PIN_IDLE = 7'h41;
    localparam int CW = $clog2(TOFF_CYC + 1);

    function automatic sms_pkg::sms_coil_t sms_sine(input logic [9:0] ph);
        logic [8:0] p;
        logic [18:0] prod;
        sms_pkg::sms_coil_t r;
        p = ph[8:0];
        prod = 19'(p) * (19'h0_0200 - 19'(p));
        r.sign = ph[9];
        r.mag = (prod[18:8] > 11'h0ff) ? 8'hff : prod[15:8];
        return r;
    endfunction : sms_sine

    // Pin synchronisers with agreement filter
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, filt_ff, prev_ff;
    assign pins = {i_chip_select_low, i_sck, i_sdi, i_step, i_dir,
                   i_ext_clk, i_driver_enable_low};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    s1_ff[g] <= PIN_IDLE[g];
                    s2_ff[g] <= PIN_IDLE[g];
                    s3_ff[g] <= PIN_IDLE[g];
                    filt_ff[g] <= PIN_IDLE[g];
                    prev_ff[g] <= PIN_IDLE[g];
                end else begin
                    s1_ff[g] <= pins[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    if (s2_ff[g] == s3_ff[g]) begin
                        filt_ff[g] <= s3_ff[g];
                    end
                    prev_ff[g] <= filt_ff[g];
                end
            end
        end
    endgenerate

    logic cs_low, sck_rise, sck_fall, cs_fall, cs_rise, sdi_s;
    logic step_rise, step_fall, dir_s, ext_clk_s, en_low_s;
    assign cs_low = ~filt_ff[6];
    assign cs_fall = prev_ff[6] & ~filt_ff[6];
    assign cs_rise = ~prev_ff[6] & filt_ff[6];
    assign sck_rise = ~prev_ff[5] & filt_ff[5];
    assign sck_fall = prev_ff[5] & ~filt_ff[5];
    assign sdi_s = filt_ff[4];
    assign step_rise = ~prev_ff[3] & filt_ff[3];
    assign step_fall = prev_ff[3] & ~filt_ff[3];
    assign dir_s = filt_ff[2];
    assign ext_clk_s = filt_ff[1];
    assign en_low_s = filt_ff[0];

    // Serial shift registers
    logic [`SMS_WORD_W-1:0] rx_ff, tx_ff;
    logic [4:0] bits_ff;
    logic cmd_ok;
    sms_pkg::sms_conf_t conf_ff;
    logic [9:0] pos_ff;
    assign cmd_ok = cs_rise && (bits_ff == 5'(`SMS_WORD_W));

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rx_ff <= '0;
            tx_ff <= '0;
            bits_ff <= 5'h00;
        end else if (cs_fall) begin
            tx_ff <= {pos_ff, o_use_ext_clk, conf_ff.step_disable,
                      1'b0, conf_ff};
            bits_ff <= 5'h00;
        end else if (cs_low) begin
            if (sck_rise) begin
                rx_ff <= {rx_ff[`SMS_WORD_W-2:0], sdi_s};
                if (bits_ff != 5'h1f) begin
                    bits_ff <= bits_ff + 5'h01;
                end
            end
            if (sck_fall) begin
                tx_ff <= {tx_ff[`SMS_WORD_W-2:0], 1'b0};
            end
        end
    end

    // Serial output, released outside chip select
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdo_oe <= cs_low;
            o_sdo <= cs_fall ? pos_ff[9] : tx_ff[`SMS_WORD_W-1];
        end
    end

    // Configuration written by controller
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            conf_ff.res <= `SMS_RST_RES;
            conf_ff.dual_edge_step_select <= `SMS_RST_DUAL_EDGE_STEP_SELECT;
            conf_ff.step_disable <= `SMS_RST_STEPDIS;
            conf_ff.chop_spread <= `SMS_RST_CHOP;
        end else if (cmd_ok && rx_ff[`SMS_KIND_HI:`SMS_KIND_LO]
                     == `SMS_KIND_CONF) begin
            if (rx_ff[`SMS_CONF_RES_HI:`SMS_CONF_RES_LO] <= `SMS_RES_MAX) begin
                conf_ff.res <= rx_ff[`SMS_CONF_RES_HI:`SMS_CONF_RES_LO];
            end
            conf_ff.dual_edge_step_select <= rx_ff[`SMS_CONF_DUAL_EDGE_STEP_SELECT];
            conf_ff.step_disable <= rx_ff[`SMS_CONF_STEPDIS];
            conf_ff.chop_spread <= rx_ff[`SMS_CONF_CHOP];
        end
    end

    // Microstep counter
    logic step_act;
    logic [9:0] step_inc;
    assign step_act = ~conf_ff.step_disable &
        (step_rise | (conf_ff.dual_edge_step_select & step_fall));
    assign step_inc = 10'h001 << conf_ff.res;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pos_ff <= 10'h000;
        end else if (step_act) begin
            if (!dir_s) begin
                pos_ff <= pos_ff + step_inc;
            end else begin
                pos_ff <= pos_ff - step_inc;
            end
        end
    end
    assign o_position = pos_ff;

    // Coil targets: table or direct write
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_coil_a <= '0;
            o_coil_b <= '0;
        end else if (conf_ff.step_disable) begin
            if (cmd_ok && rx_ff[`SMS_KIND_HI:`SMS_KIND_LO]
                == `SMS_KIND_COIL) begin
                o_coil_a <= rx_ff[`SMS_COILA_SIGN:`SMS_COILA_LO];
                o_coil_b <= rx_ff[`SMS_COILB_SIGN:`SMS_COILB_LO];
            end
        end else begin
            o_coil_a <= sms_sine(pos_ff);
            o_coil_b <= sms_sine(pos_ff + 10'h100);
        end
    end

    // External clock detection, held until reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_use_ext_clk <= 1'b0;
        end else if (ext_clk_s) begin
            o_use_ext_clk <= 1'b1;
        end
    end

    // Chopper per coil
    sms_pkg::sms_coil_t coil [2];
    assign coil[0] = o_coil_a;
    assign coil[1] = o_coil_b;

    generate
        for (g = 0; g < 2; g++) begin : g_chop
            sms_pkg::sms_chop_t st_ff;
            logic [CW-1:0] cnt_ff;
            logic [3:0] drv;
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    st_ff <= sms_pkg::SMS_CH_SLOW;
                    cnt_ff <= '0;
                end else begin
                    unique case (st_ff)
                        sms_pkg::SMS_CH_ON: begin
                            if (i_coil_over[g] || coil[g].mag == 8'h00) begin
                                st_ff <= conf_ff.chop_spread ?
                                    sms_pkg::SMS_CH_FAST :
                                    sms_pkg::SMS_CH_SLOW;
                                cnt_ff <= CW'(TOFF_CYC - 1);
                            end
                        end
                        sms_pkg::SMS_CH_FAST: begin
                            cnt_ff <= cnt_ff - 1'b1;
                            if (cnt_ff <= CW'(TOFF_CYC - TFAST_CYC)) begin
                                st_ff <= sms_pkg::SMS_CH_SLOW;
                            end
                        end
                        sms_pkg::SMS_CH_SLOW: begin
                            if (cnt_ff != '0) begin
                                cnt_ff <= cnt_ff - 1'b1;
                            end else if (coil[g].mag != 8'h00) begin
                                st_ff <= sms_pkg::SMS_CH_ON;
                            end
                        end
                        default: begin
                            st_ff <= sms_pkg::SMS_CH_SLOW;
                        end
                    endcase
                end
            end
            always_comb begin
                unique case (st_ff)
                    sms_pkg::SMS_CH_ON:
                        drv = coil[g].sign ? 4'b0110 : 4'b1001;
                    sms_pkg::SMS_CH_FAST:
                        drv = coil[g].sign ? 4'b1001 : 4'b0110;
                    default:
                        drv = 4'b0011;
                endcase
            end
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    o_bridge[4*g+3:4*g] <= 4'h0;
                end else if (en_low_s) begin
                    o_bridge[4*g+3:4*g] <= 4'h0;
                end else begin
                    o_bridge[4*g+3:4*g] <= drv;
                end
            end
        end
    endgenerate
endmodule : sms_sequencer

// [bench/sms_checker.sv]
// Purpose: Port assertions for the step/dir sequencer
// Assumes: Pins are held for at least four system clocks
// Notes: Bound to every instance of the sequencer
`timescale 1ns/1ps
module sms_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_chip_select_low,
    input wire logic i_step,
    input wire logic i_ext_clk,
    input wire logic i_driver_enable_low,
    input wire logic o_sdo_oe,
    input wire logic o_use_ext_clk,
    input wire logic [7:0] o_bridge,
    input wire logic [9:0] o_position
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    function automatic logic p2(logic [9:0] d);
        return (d != 10'h000) && ((d & (d - 10'h001)) == 10'h000);
    endfunction : p2
    a_ext_sticky: assert property (o_use_ext_clk |=> o_use_ext_clk)
        else $error("external clock select dropped");
    a_ext_taken: assert property (i_ext_clk [*7] |-> o_use_ext_clk)
        else $error("external clock high not taken");
    a_bridge_off: assert property (i_driver_enable_low [*7] |->
        o_bridge == 8'h00) else $error("bridge driven while disabled");
    a_no_shoot: assert property (!(|(o_bridge[7:6] & o_bridge[5:4]) ||
        |(o_bridge[3:2] & o_bridge[1:0]))) else $error("shoot-through");
    a_sdo_free: assert property (i_chip_select_low [*7] |->
        !o_sdo_oe) else $error("data out driven while deselected");
    a_sdo_drive: assert property (!i_chip_select_low [*7] |->
        o_sdo_oe) else $error("data out not driven while selected");
    a_pos_quiet: assert property ($stable(i_step) [*8] |->
        $stable(o_position)) else $error("position moved without step");
    a_pos_stride: assert property ($changed(o_position) |->
        p2(o_position - $past(o_position)) ||
        p2($past(o_position) - o_position)) else $error("bad stride");
    cover property ($rose(o_use_ext_clk));
    cover property ($changed(o_position));
    cover property ($rose(o_sdo_oe));
endmodule : sms_checker
bind sms_sequencer sms_checker i_chk (.i_clk_sys, .i_rst,
    .i_chip_select_low, .i_step, .i_ext_clk, .i_driver_enable_low,
    .o_sdo_oe, .o_use_ext_clk, .o_bridge, .o_position);

// [bench/sms_ctrl_model.sv]
// Purpose: Controller side: serial master and step/dir source
// Assumes: Changes its pins at the falling system clock edge
// Notes: Serial clock idles low, eight system clocks a period
`timescale 1ns/1ps
module sms_ctrl_model (
    // Clock and returned data
    input wire logic i_clk_sys,
    input wire logic i_sdo,
    // Pins toward the device
    output logic o_chip_select_low,
    output logic o_sck,
    output logic o_sdi,
    output logic o_step,
    output logic o_dir
);
    initial begin
        o_chip_select_low = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_step = 1'b0;
        o_dir = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : wt
    // Short frames are sent on purpose only by the bench
    task automatic xfer(input logic [19:0] cmd, input int nb,
                        output logic [19:0] st);
        st = 20'h0_0000;
        o_chip_select_low = 1'b0;
        wt(8);
        for (int i = 19; i > 19 - nb; i--) begin
            o_sdi = cmd[i];
            wt(4);
            o_sck = 1'b1;
            wt(4);
            st[i] = i_sdo;
            o_sck = 1'b0;
        end
        wt(4);
        o_chip_select_low = 1'b1;
        wt(12);
    endtask : xfer
    // Direction settles before the edge and holds after it
    task automatic edge_to(input logic lvl, input logic d);
        o_dir = d;
        wt(4);
        o_step = lvl;
        wt(8);
    endtask : edge_to
endmodule : sms_ctrl_model

// [bench/testbench.sv]
// Purpose: Self-checking bench of the step/dir sequencer
// Assumes: Inputs change at the falling clock edge
// Notes: Off times shortened to 4 and 2 clocks
`timescale 1ns/1ps
module testbench;
    logic i_clk_sys;
    logic i_rst;
    logic i_ext_clk;
    logic i_driver_enable_low;
    logic [1:0] i_coil_over;
    logic i_chip_select_low, i_sck, i_sdi, i_step, i_dir;
    logic o_sdo, o_sdo_oe, o_use_ext_clk, sdo_hold, sdo_line;
    sms_pkg::sms_coil_t o_coil_a, o_coil_b;
    logic [7:0] o_bridge;
    logic [9:0] o_position, ep;
    logic [19:0] st;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    sms_sequencer #(.TOFF_CYC(4), .TFAST_CYC(2)) i_dut (.i_clk_sys,
        .i_rst, .i_chip_select_low, .i_sck, .i_sdi, .o_sdo, .o_sdo_oe,
        .i_step, .i_dir, .i_ext_clk, .i_driver_enable_low,
        .o_use_ext_clk, .i_coil_over, .o_coil_a, .o_coil_b, .o_bridge,
        .o_position);
    sms_ctrl_model i_ctrl (.i_clk_sys, .i_sdo(sdo_line),
        .o_chip_select_low(i_chip_select_low), .o_sck(i_sck),
        .o_sdi(i_sdi), .o_step(i_step), .o_dir(i_dir));
    // Released data line shows the inverse of its last level
    always @(posedge i_clk_sys) if (o_sdo_oe) sdo_hold <= o_sdo;
    assign sdo_line = o_sdo_oe ? o_sdo : ~sdo_hold;
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [19:0] e,
                       input logic [19:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wbr(input logic [7:0] e);
        for (int i = 0; i < 40 && o_bridge !== e; i++) i_ctrl.wt(1);
        chk("bridge", {12'h000, e}, {12'h000, o_bridge});
    endtask : wbr
    task automatic t_step;
        chk("pos", 20'h0_0000, o_position);
        chk("coil a", 20'h0_0000, o_coil_a);
        chk("coil b", 20'h0_00FF, o_coil_b);
        i_ctrl.edge_to(1'b1, 1'b0);
        chk("pos", 20'h0_0001, o_position);
        i_ctrl.edge_to(1'b0, 1'b0);
        chk("pos", 20'h0_0001, o_position);
        i_ctrl.edge_to(1'b1, 1'b1);
        i_ctrl.edge_to(1'b0, 1'b1);
        i_ctrl.edge_to(1'b1, 1'b1);
        chk("pos", 20'h0_03FF, o_position);
        ep = 10'h3FF;
        $display("test step done");
    endtask : t_step
    task automatic t_res;
        for (int r = 1; r <= 8; r++) begin
            i_ctrl.xfer(20'h4_0000 | 20'(r), 20, st);
            chk("stat pos", ep, st[19:10]);
            chk("stat res", 20'(r - 1), st[3:0]);
            i_ctrl.edge_to(1'b0, 1'b0);
            i_ctrl.edge_to(1'b1, 1'b0);
            ep = ep + (10'h001 << r);
            chk("pos", ep, o_position);
        end
        i_ctrl.xfer(20'h4_001A, 20, st);
        i_ctrl.edge_to(1'b0, 1'b1);
        i_ctrl.edge_to(1'b1, 1'b1);
        ep = ep - 10'h200;
        chk("pos", ep, o_position);
        chk("sign", ep[9], o_coil_a.sign);
        // Short frame would land as a resolution 0 write if taken
        i_ctrl.xfer(20'h8_0000, 19, st);
        i_ctrl.xfer(20'h4_0000, 20, st);
        chk("stat conf", 20'h0_0018, st[6:0]);
        $display("test resolution done");
    endtask : t_res
    task automatic t_coil;
        sms_pkg::sms_coil_t ca;
        ca = o_coil_a;
        i_ctrl.xfer(20'h1_0140, 20, st);
        chk("coil a", ca, o_coil_a);
        i_ctrl.xfer(20'h4_0020, 20, st);
        i_ctrl.xfer(20'h1_0140, 20, st);
        chk("coil a", 20'h0_0080, o_coil_a);
        chk("coil b", 20'h0_0140, o_coil_b);
        i_ctrl.edge_to(1'b0, 1'b0);
        i_ctrl.edge_to(1'b1, 1'b0);
        chk("pos", ep, o_position);
        $display("test coil done");
    endtask : t_coil
    task automatic t_chop;
        i_driver_enable_low = 1'b0;
        wbr(8'h69);
        i_coil_over = 2'b01;
        wbr(8'h63);
        i_coil_over = 2'b00;
        i_ctrl.xfer(20'h4_0060, 20, st);
        i_coil_over = 2'b01;
        wbr(8'h66);
        i_coil_over = 2'b00;
        wbr(8'h69);
        i_coil_over = 2'b10;
        wbr(8'h99);
        i_coil_over = 2'b00;
        i_driver_enable_low = 1'b1;
        wbr(8'h00);
        i_ext_clk = 1'b1;
        i_ctrl.wt(10);
        i_ext_clk = 1'b0;
        i_ctrl.wt(10);
        chk("ext clk", 20'h0_0001, o_use_ext_clk);
        $display("test chopper done");
    endtask : t_chop
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        i_rst = 1'b1;
        i_ext_clk = 1'b0;
        i_driver_enable_low = 1'b1;
        i_coil_over = 2'b00;
        sdo_hold = 1'b0;
        ep = 10'h000;
        repeat (6) @(negedge i_clk_sys);
        i_rst = 1'b0;
        i_ctrl.wt(6);
        t_step();
        t_res();
        t_coil();
        t_chop();
        report_and_stop();
    end
endmodule : testbench
